// File: core/ascl_top.sv
// interrupt masking, switch sequencing, key reporting and power save control
`timescale 1ns/1ps

// What this block does
// - masked: pin low, flags still set
// - unmask: pin high one wait, then flags
// - pin low at expiry, release set: wait again
// - flags clear on read, pin returns high
// - release clear at expiry: switches stay open
// - unmasked: pin low when any flag sets
// - unmasked attach: wait then close, or hold
// - global enable low opens all, fet off
// - auto select: outputs from identification result
// - manual select: outputs from manual configuration, fet off
// - select bits never change sequencing timing
// - standby keeps every switch open
// - auto to manual while attached: swap sources
// - back to auto leaves outputs unchanged
// - key mode matters only for remote audio
// - event mode: adc on id event, key flags
// - periodic mode: adc change flag, no keys
// - periodic interval from wake-up field
// - audio or tty: idle timeout enters power save
// - activity leaves power save at once
// - auto off: forced bit picks the mode
// - masked after power up: switches stay open, except a factory cable closes them at once

module ascl_top
    import ascl_pkg::*;
#(
    parameter int MS_TICK_CYCLES = MS_TICK_CYCLES_DOC
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // control bits from the host
    input wire logic int_mask,
    input wire logic wait_release,
    input wire logic switch_enable,
    input wire logic manual_select,
    input wire logic key_report_mode,
    input wire logic auto_power_save_enable,
    input wire logic forced_power_save,
    input wire logic flags_read,
    // timing fields
    input wire logic [SW_WAIT_SEL_W-1:0] switching_wait_sel,
    input wire logic [WAKE_SEL_W-1:0] wakeup_sel,
    input wire logic [IDLE_SEL_W-1:0] idle_sel,
    // manual configuration
    input wire logic [NUM_SW-1:0] manual_switch_cfg,
    input wire logic [NUM_PINS-1:0] manual_pin_cfg,
    // identification result
    input wire logic attach_evt,
    input wire logic detach_evt,
    input wire logic is_factory_cable,
    input wire logic is_audio_key,
    input wire logic is_audio_or_tty,
    input wire logic [NUM_SW-1:0] auto_switch_cfg,
    input wire logic [NUM_PINS-1:0] auto_pin_cfg,
    // key and adc events
    input wire logic id_line_evt,
    input wire logic key_short_evt,
    input wire logic key_long_evt,
    input wire logic key_release_evt,
    input wire logic [NUM_BUTTONS-1:0] key_button,
    input wire logic adc_done,
    input wire logic [ADC_W-1:0] adc_result,
    input wire logic signal_activity,
    // host interrupt and flags
    output logic host_interrupt_n,
    output logic attach_flag,
    output logic short_key_press_flag,
    output logic long_key_press_flag,
    output logic long_key_release_flag,
    output logic adc_change_flag,
    output logic [NUM_BUTTONS-1:0] button_bits,
    // switch matrix and pins
    output logic [NUM_SW-1:0] switch_close,
    output logic charge_current_select_out,
    output logic factory_cable_out,
    output logic boot_out,
    // adc and mode status
    output logic adc_start,
    output logic power_save_active
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (SW_FET_IDX >= NUM_SW)
    begin : g_bad_fet
        $error("power fet index outside switch vector");
    end

    // ------------------------------------------------------------
    // delay decoding
    // ------------------------------------------------------------

    // switching wait in ms, used by unmask delay and switch wait
    function automatic logic [MS_CNT_W-1:0] wait_ms(input logic [SW_WAIT_SEL_W-1:0] sel);
        wait_ms = MS_CNT_W'((MS_CNT_W'(sel) + MS_CNT_W'(1)) * SW_WAIT_STEP_MS);
    endfunction

    logic ms_tick;
    logic [MS_CNT_W-1:0] wake_ms;
    logic [MS_CNT_W-1:0] idle_ms;

    ascl_ms_tick #(
        .TICK_CYCLES(MS_TICK_CYCLES)
    ) u_tick (
        .clk(clk),
        .reset_n(reset_n),
        .tick(ms_tick)
    );

    // interval and idle limit from their fields
    assign wake_ms = MS_CNT_W'((MS_CNT_W'(wakeup_sel) + MS_CNT_W'(1)) * WAKE_STEP_MS);
    assign idle_ms = MS_CNT_W'((MS_CNT_W'(idle_sel) + MS_CNT_W'(1)) * IDLE_STEP_MS);

    // ------------------------------------------------------------
    // attach state and unmask delay
    // ------------------------------------------------------------
    logic attached_q;
    logic mask_prev_q;
    logic [MS_CNT_W-1:0] unmask_cnt_q;
    logic [MS_CNT_W-1:0] unmask_cnt_d;
    logic mask_fall;
    logic unmask_busy;
    logic unmask_done;

    assign mask_fall = mask_prev_q && !int_mask;
    assign unmask_busy = (unmask_cnt_q != '0);
    assign unmask_done = unmask_busy && ms_tick && (unmask_cnt_q == MS_CNT_W'(1)) && !int_mask;
    // delay restarts on each unmask, aborts if masked again
    assign unmask_cnt_d = int_mask ? '0 :
                          mask_fall ? wait_ms(switching_wait_sel) :
                          (unmask_busy && ms_tick) ? unmask_cnt_q - MS_CNT_W'(1) : unmask_cnt_q;

    // attach tracking and unmask delay counter
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            attached_q <= 1'b0;
            mask_prev_q <= RST_MASK_PREV;
            unmask_cnt_q <= '0;
        end
        else
        begin
            attached_q <= attach_evt ? 1'b1 : (detach_evt ? 1'b0 : attached_q);
            mask_prev_q <= int_mask;
            unmask_cnt_q <= unmask_cnt_d;
        end
    end

    // ------------------------------------------------------------
    // interrupt flags
    // ------------------------------------------------------------
    logic [NUM_FLAGS-1:0] flag_q;
    logic [NUM_FLAGS-1:0] flag_set;
    logic key_mode_on;
    logic periodic_on;
    logic adc_differs;
    logic [ADC_W-1:0] adc_last_q;
    logic [NUM_BUTTONS-1:0] button_d;
    logic any_key;

    // key mode only acts on a remote capable audio accessory
    assign key_mode_on = attached_q && is_audio_key && key_report_mode;
    assign periodic_on = attached_q && is_audio_key && !key_report_mode;
    assign adc_differs = adc_done && (adc_result != adc_last_q);
    assign any_key = key_short_evt || key_long_evt || key_release_evt;

    // events set flags regardless of the mask
    assign flag_set[FLG_ATTACH] = attach_evt;
    assign flag_set[FLG_KP] = key_mode_on && key_short_evt;
    assign flag_set[FLG_LKP] = key_mode_on && key_long_evt;
    assign flag_set[FLG_LKR] = key_mode_on && key_release_evt;
    assign flag_set[FLG_ADC] = periodic_on && adc_differs;

    // button bits only in key event mode, set wins over read
    assign button_d = ((key_mode_on && any_key) ? key_button : '0)
                    | (button_bits & ~{NUM_BUTTONS{flags_read}});

    // one sticky flag per event, cleared by a host read
    for (genvar i = 0; i < NUM_FLAGS; i++)
    begin : g_flag
        always_ff @(posedge clk or negedge reset_n)
        begin
            if (!reset_n)
                flag_q[i] <= 1'b0;
            else
                flag_q[i] <= flag_set[i] || (flag_q[i] && !flags_read);
        end
    end

    // last conversion and button bits
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            adc_last_q <= '0;
            button_bits <= '0;
        end
        else
        begin
            adc_last_q <= adc_done ? adc_result : adc_last_q;
            button_bits <= button_d;
        end
    end

    assign attach_flag = flag_q[FLG_ATTACH];
    assign short_key_press_flag = flag_q[FLG_KP];
    assign long_key_press_flag = flag_q[FLG_LKP];
    assign long_key_release_flag = flag_q[FLG_LKR];
    assign adc_change_flag = flag_q[FLG_ADC];

    // ------------------------------------------------------------
    // host interrupt pin
    // ------------------------------------------------------------
    logic int_n_d;

    // low while masked, high during unmask delay, else flags
    assign int_n_d = int_mask ? 1'b0 :
                     (mask_fall || unmask_busy) ? 1'b1 :
                     !(|flag_q);

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            host_interrupt_n <= RST_INT_N;
        else
            host_interrupt_n <= int_n_d;
    end

    // ------------------------------------------------------------
    // switch sequencing
    // ------------------------------------------------------------
    ascl_sw_state_e sw_q;
    ascl_sw_state_e sw_d;
    logic [MS_CNT_W-1:0] sw_cnt_q;
    logic [MS_CNT_W-1:0] sw_cnt_d;
    logic sw_load;
    logic sw_done;

    assign sw_done = (sw_q == SW_WAIT) && ms_tick && (sw_cnt_q <= MS_CNT_W'(1));
    assign sw_cnt_d = sw_load ? wait_ms(switching_wait_sel) :
                      (ms_tick && sw_cnt_q != '0) ? sw_cnt_q - MS_CNT_W'(1) : sw_cnt_q;

    // sequencing never looks at the enable or select bits
    always_comb
    begin
        sw_d = sw_q;
        sw_load = 1'b0;
        case (sw_q)
            SW_OPEN:
            begin
                if (attach_evt && is_factory_cable && int_mask)
                    sw_d = SW_CLOSED;
                else if (attach_evt && (int_mask || mask_fall || (unmask_busy && !unmask_done)))
                    sw_d = SW_MASKED;
                else if (attach_evt && wait_release)
                begin
                    sw_d = SW_WAIT;
                    sw_load = 1'b1;
                end
                else if (attach_evt)
                    sw_d = SW_HOLD;
            end
            SW_MASKED:
            begin
                if (unmask_done && wait_release)
                begin
                    sw_d = SW_WAIT;
                    sw_load = 1'b1;
                end
                else if (unmask_done)
                    sw_d = SW_HOLD;
            end
            SW_HOLD:
            begin
                if (wait_release)
                    sw_d = SW_CLOSED;
            end
            SW_WAIT:
            begin
                if (sw_done)
                    sw_d = SW_CLOSED;
            end
            SW_CLOSED:
                sw_d = SW_CLOSED;
            default:
                sw_d = SW_OPEN;
        endcase
        if (detach_evt)
            sw_d = SW_OPEN;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sw_q <= SW_OPEN;
            sw_cnt_q <= '0;
        end
        else
        begin
            sw_q <= sw_d;
            sw_cnt_q <= sw_cnt_d;
        end
    end

    // ------------------------------------------------------------
    // switch and pin sources
    // ------------------------------------------------------------
    logic use_manual_q;
    logic use_manual_d;
    logic closed_now;
    logic [NUM_SW-1:0] sel_sw;
    logic [NUM_PINS-1:0] sel_pin;
    logic [NUM_SW-1:0] switch_d;
    logic [NUM_PINS-1:0] pin_d;

    // manual source latched on attach, sticky once chosen while attached
    assign use_manual_d = attach_evt ? !manual_select :
                          (attached_q && !manual_select) ? 1'b1 :
                          use_manual_q;
    assign closed_now = (sw_q == SW_CLOSED) && attached_q;
    assign sel_sw = use_manual_q ? (manual_switch_cfg & ~(NUM_SW'(1) << SW_FET_IDX))
                                 : auto_switch_cfg;
    assign sel_pin = use_manual_q ? manual_pin_cfg : auto_pin_cfg;
    assign switch_d = (closed_now && switch_enable) ? sel_sw : '0;
    assign pin_d = closed_now ? sel_pin : '0;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            use_manual_q <= 1'b0;
            switch_close <= '0;
            charge_current_select_out <= 1'b0;
            factory_cable_out <= 1'b0;
            boot_out <= 1'b0;
        end
        else
        begin
            use_manual_q <= use_manual_d;
            switch_close <= switch_d;
            charge_current_select_out <= pin_d[PIN_CHARGE_CURRENT_SELECT_OUT_IDX];
            factory_cable_out <= pin_d[PIN_JIG_IDX];
            boot_out <= pin_d[PIN_BOOT_IDX];
        end
    end

    // ------------------------------------------------------------
    // adc start requests
    // ------------------------------------------------------------
    logic [MS_CNT_W-1:0] adc_cnt_q;
    logic adc_period_hit;
    logic adc_start_d;

    assign adc_period_hit = periodic_on && ms_tick && (adc_cnt_q >= wake_ms - MS_CNT_W'(1));
    assign adc_start_d = (key_mode_on && id_line_evt) || adc_period_hit;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            adc_cnt_q <= '0;
            adc_start <= 1'b0;
        end
        else
        begin
            adc_cnt_q <= (!periodic_on || adc_period_hit) ? '0 :
                         ms_tick ? adc_cnt_q + MS_CNT_W'(1) : adc_cnt_q;
            adc_start <= adc_start_d;
        end
    end

    // ------------------------------------------------------------
    // power save
    // ------------------------------------------------------------
    logic ps_eligible;
    logic [MS_CNT_W-1:0] idle_cnt_q;
    logic idle_hit;
    logic ps_d;

    assign ps_eligible = attached_q && is_audio_or_tty;
    assign idle_hit = (idle_cnt_q >= idle_ms);
    // forced bit rules when auto entry is off, activity exits at once
    assign ps_d = !ps_eligible ? 1'b0 :
                  !auto_power_save_enable ? forced_power_save :
                  signal_activity ? 1'b0 :
                  idle_hit ? 1'b1 : power_save_active;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            idle_cnt_q <= '0;
            power_save_active <= 1'b0;
        end
        else
        begin
            idle_cnt_q <= (!ps_eligible || !auto_power_save_enable || signal_activity) ? '0 :
                          (ms_tick && !idle_hit) ? idle_cnt_q + MS_CNT_W'(1) : idle_cnt_q;
            power_save_active <= ps_d;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    property p_mask_low;
        int_mask |=> !host_interrupt_n;
    endproperty
    a_mask_low: assert property (p_mask_low) else $error("pin not low while masked");

    property p_flag_under_mask;
        int_mask && attach_evt |=> attach_flag;
    endproperty
    a_flag_under_mask: assert property (p_flag_under_mask) else $error("flag lost under mask");

    property p_unmask_high;
        mask_fall |=> host_interrupt_n [*2];
    endproperty
    a_unmask_high: assert property (p_unmask_high) else $error("pin not high after unmask");

    property p_read_clears;
        flags_read && !attach_evt |=> !attach_flag;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("attach flag survived read");

    property p_unmasked_low;
        !int_mask && !mask_fall && !unmask_busy && attach_evt ##1 !int_mask && !unmask_busy
            |=> !host_interrupt_n;
    endproperty
    a_unmasked_low: assert property (p_unmasked_low) else $error("pin not low after flag");

    property p_enable_off;
        !switch_enable |=> switch_close == '0;
    endproperty
    a_enable_off: assert property (p_enable_off) else $error("switch closed while disabled");

    property p_standby_open;
        !attached_q |=> switch_close == '0 && !factory_cable_out;
    endproperty
    a_standby_open: assert property (p_standby_open) else $error("switch closed in standby");

    property p_hold_open;
        sw_q == SW_HOLD && !wait_release |=> switch_close == '0;
    endproperty
    a_hold_open: assert property (p_hold_open) else $error("switch closed while held");

    property p_periodic_no_key;
        periodic_on && !short_key_press_flag |=> !short_key_press_flag;
    endproperty
    a_periodic_no_key: assert property (p_periodic_no_key) else $error("key flag in periodic mode");

    property p_ps_exit;
        ps_eligible && auto_power_save_enable && signal_activity |=> !power_save_active;
    endproperty
    a_ps_exit: assert property (p_ps_exit) else $error("power save kept on activity");

    property p_forced;
        ps_eligible && !auto_power_save_enable |=> power_save_active == $past(forced_power_save);
    endproperty
    a_forced: assert property (p_forced) else $error("forced power save ignored");

endmodule // ascl_top

// File: pkg/ascl_pkg.sv
// constants shared by the accessory switch control logic
package ascl_pkg;

    // ------------------------------------------------------------
    // clock and time base
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int MS_IN_NS = 1000000;
    localparam int MS_TICK_CYCLES_DOC = MS_IN_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // programmable delays, all counted in millisecond ticks
    // ------------------------------------------------------------
    localparam int MS_CNT_W = 15;
    localparam logic [MS_CNT_W-1:0] SW_WAIT_STEP_MS = 15'h0064;
    localparam logic [MS_CNT_W-1:0] WAKE_STEP_MS = 15'h0032;
    localparam logic [MS_CNT_W-1:0] IDLE_STEP_MS = 15'h07D0;
    localparam int SW_WAIT_SEL_W = 4;
    localparam int WAKE_SEL_W = 3;
    localparam int IDLE_SEL_W = 3;
    localparam logic [IDLE_SEL_W-1:0] IDLE_SEL_DEFAULT = 3'h4;

    // ------------------------------------------------------------
    // switch matrix, pin outputs and flags
    // ------------------------------------------------------------
    localparam int NUM_SW = 10;
    localparam int SW_FET_IDX = 7;
    localparam int PIN_CHARGE_CURRENT_SELECT_OUT_IDX = 0;
    localparam int PIN_JIG_IDX = 1;
    localparam int PIN_BOOT_IDX = 2;
    localparam int NUM_PINS = 3;
    localparam int NUM_BUTTONS = 13;
    localparam int ADC_W = 5;
    localparam int NUM_FLAGS = 5;
    localparam int FLG_ATTACH = 0;
    localparam int FLG_KP = 1;
    localparam int FLG_LKP = 2;
    localparam int FLG_LKR = 3;
    localparam int FLG_ADC = 4;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic RST_INT_N = 1'b0;
    localparam logic RST_MASK_PREV = 1'b1;

    // switch sequencing states
    typedef enum logic [2:0] {
        SW_OPEN,
        SW_MASKED,
        SW_HOLD,
        SW_WAIT,
        SW_CLOSED
    } ascl_sw_state_e;

endpackage

// File: core/ascl_ms_tick.sv
// millisecond enable pulse divider
`timescale 1ns/1ps

module ascl_ms_tick
    import ascl_pkg::*;
#(
    parameter int TICK_CYCLES = MS_TICK_CYCLES_DOC
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // one-cycle enable every tick period
    output logic tick
);

    localparam int CW = $clog2(TICK_CYCLES);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (TICK_CYCLES < 2)
    begin : g_bad_tick
        $error("tick divider needs at least two cycles");
    end

    logic [CW-1:0] div_q;
    logic [CW-1:0] div_d;
    logic wrap;

    // wrap at the last count of the period
    assign wrap = (div_q == CW'(TICK_CYCLES - 1));
    assign div_d = wrap ? '0 : div_q + CW'(1);

    // free running divider with registered pulse
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            div_q <= '0;
            tick <= 1'b0;
        end
        else
        begin
            div_q <= div_d;
            tick <= wrap;
        end
    end

endmodule // ascl_ms_tick

// File: verif/ascl_host_model.sv
// host model that reads the flag registers after the interrupt pin falls
`timescale 1ns/1ps

module ascl_host_model
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // host enable and device pins
    input wire logic read_en,
    input wire logic int_mask,
    input wire logic host_interrupt_n,
    // one-cycle flag read
    output logic flags_read
);
    logic [1:0] low_cnt_q;

    // read only while unmasked and the pin is low, never during the delay
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            low_cnt_q <= 2'h0;
            flags_read <= 1'b0;
        end
        else
        begin
            low_cnt_q <= (host_interrupt_n || int_mask || !read_en) ? 2'h0 : low_cnt_q + 2'h1;
            flags_read <= (low_cnt_q == 2'h3);
        end
    end
endmodule // ascl_host_model

// File: verif/tb_ascl_top.sv
// self-checking bench for the accessory switch control logic
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end
`define WT(c, n) begin for (int k = 0; k < n && !(c); k++) begin @(posedge clk); #1; end \
    if (!(c)) begin mismatches++; results(); end end
`define PULSE(s) begin s <= 1'b1; @(posedge clk); s <= 1'b0; end

module tb_ascl_top;
    import ascl_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, flags_read, read_en = 1'b0;
    logic int_mask = 1'b1, wait_release = 1'b1, switch_enable = 1'b1, manual_select = 1'b1;
    logic key_report_mode = 1'b1, auto_power_save_enable = 1'b0, forced_power_save = 1'b0;
    logic [SW_WAIT_SEL_W-1:0] switching_wait_sel = 4'h0;
    logic [WAKE_SEL_W-1:0] wakeup_sel = 3'h7;
    logic [IDLE_SEL_W-1:0] idle_sel = IDLE_SEL_DEFAULT;
    logic [NUM_SW-1:0] manual_switch_cfg = 10'h083, auto_switch_cfg = 10'h398, switch_close;
    logic [NUM_PINS-1:0] manual_pin_cfg = 3'h2, auto_pin_cfg = 3'h5;
    logic attach_evt = 1'b0, detach_evt = 1'b0, is_factory_cable = 1'b0, is_audio_key = 1'b1;
    logic is_audio_or_tty = 1'b1, id_line_evt = 1'b0, adc_done = 1'b0, signal_activity = 1'b0;
    logic key_short_evt = 1'b0, key_long_evt = 1'b0, key_release_evt = 1'b0;
    logic [NUM_BUTTONS-1:0] key_button = 13'h0004, button_bits;
    logic [ADC_W-1:0] adc_result = 5'h03;
    logic host_interrupt_n, attach_flag, short_key_press_flag, long_key_press_flag, long_key_release_flag;
    logic adc_change_flag, charge_current_select_out, factory_cable_out, boot_out, adc_start, power_save_active;
    int mismatches = 0, total_checks = 0;

    // 200 MHz clock
    initial
    begin
        forever #2.5 clk = ~clk;
    end

    ascl_top #(.MS_TICK_CYCLES(4)) i_ascl_top (.clk, .reset_n, .int_mask, .wait_release, .switch_enable,
        .manual_select, .key_report_mode, .auto_power_save_enable, .forced_power_save, .flags_read,
        .switching_wait_sel, .wakeup_sel, .idle_sel, .manual_switch_cfg, .manual_pin_cfg, .attach_evt,
        .detach_evt, .is_factory_cable, .is_audio_key, .is_audio_or_tty, .auto_switch_cfg, .auto_pin_cfg,
        .id_line_evt, .key_short_evt, .key_long_evt, .key_release_evt, .key_button, .adc_done, .adc_result,
        .signal_activity, .host_interrupt_n, .attach_flag, .short_key_press_flag, .long_key_press_flag,
        .long_key_release_flag, .adc_change_flag, .button_bits, .switch_close, .charge_current_select_out,
        .factory_cable_out, .boot_out, .adc_start, .power_save_active);
    ascl_host_model i_ascl_host_model (.clk, .reset_n, .read_en, .int_mask, .host_interrupt_n, .flags_read);

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic masked_attach();
        @(posedge clk);
        `PULSE(attach_evt)
        repeat (3) @(posedge clk);
        #1;
        `CHK(host_interrupt_n, 1'b0)
        `CHK(attach_flag, 1'b1)
        `CHK(switch_close, 10'h000)
    endtask

    task automatic unmask_release();
        @(posedge clk);
        int_mask <= 1'b0;
        repeat (300) @(posedge clk);
        #1;
        `CHK(host_interrupt_n, 1'b1)
        `WT(host_interrupt_n === 1'b0, 200)
        `CHK(switch_close, 10'h000)
        @(posedge clk);
        read_en <= 1'b1;
        repeat (300) @(posedge clk);
        #1;
        `CHK(switch_close, 10'h000)
        `WT(switch_close === 10'h398, 200)
        `CHK({boot_out, factory_cable_out, charge_current_select_out}, 3'h5)
        `CHK(host_interrupt_n, 1'b1)
        `CHK(attach_flag, 1'b0)
    endtask

    // manual swap, return to auto, global open, detach
    task automatic manual_swap();
        @(posedge clk);
        manual_select <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        `CHK(switch_close, 10'h003)
        `CHK({boot_out, factory_cable_out, charge_current_select_out}, 3'h2)
        @(posedge clk);
        manual_select <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        `CHK(switch_close, 10'h003)
        @(posedge clk);
        switch_enable <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        `CHK(switch_close, 10'h000)
        @(posedge clk);
        switch_enable <= 1'b1;
        `PULSE(detach_evt)
        repeat (3) @(posedge clk);
        #1;
        `CHK(switch_close, 10'h000)
    endtask

    task automatic unmasked_hold();
        @(posedge clk);
        wait_release <= 1'b0;
        read_en <= 1'b0;
        `PULSE(attach_evt)
        `WT(host_interrupt_n === 1'b0, 4)
        `CHK(attach_flag, 1'b1)
        repeat (500) @(posedge clk);
        #1;
        `CHK(switch_close, 10'h000)
        @(posedge clk);
        wait_release <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        `CHK(switch_close, 10'h398)
    endtask

    task automatic clear();
        @(posedge clk);
        read_en <= 1'b1;
        #1;
        `WT(host_interrupt_n === 1'b1, 20)
        @(posedge clk);
        read_en <= 1'b0;
    endtask

    task automatic keys3(input logic [2:0] exp);
        @(posedge clk);
        {key_short_evt, key_long_evt, key_release_evt} <= 3'h7;
        @(posedge clk);
        {key_short_evt, key_long_evt, key_release_evt} <= 3'h0;
        repeat (2) @(posedge clk);
        #1;
        `CHK({short_key_press_flag, long_key_press_flag, long_key_release_flag}, exp)
    endtask

    task automatic keys();
        clear();
        `PULSE(id_line_evt)
        #1;
        `CHK(adc_start, 1'b1)
        keys3(3'h7);
        `CHK(button_bits, 13'h0004)
        clear();
        key_report_mode <= 1'b0;
        keys3(3'h0);
        // periodic starts come one wake-up interval apart
        `WT(adc_start === 1'b1, 1700)
        repeat (1500) @(posedge clk);
        `WT(adc_start === 1'b1, 200)
        `CHK(adc_start, 1'b1)
        @(posedge clk);
        `PULSE(adc_done)
        clear();
        `PULSE(adc_done)
        repeat (2) @(posedge clk);
        #1;
        `CHK(adc_change_flag, 1'b0)
        @(posedge clk);
        adc_result <= 5'h07;
        `PULSE(adc_done)
        repeat (2) @(posedge clk);
        #1;
        `CHK(adc_change_flag, 1'b1)
        `CHK(button_bits, 13'h0000)
        clear();
        key_report_mode <= 1'b1;
        is_audio_key <= 1'b0;
        keys3(3'h0);
    endtask

    task automatic power();
        @(posedge clk);
        forced_power_save <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        `CHK(power_save_active, 1'b1)
        @(posedge clk);
        forced_power_save <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        `CHK(power_save_active, 1'b0)
        @(posedge clk);
        auto_power_save_enable <= 1'b1;
        idle_sel <= 3'h0;
        `WT(power_save_active === 1'b1, 8200)
        `CHK(switch_close, 10'h398)
        @(posedge clk);
        `PULSE(signal_activity)
        @(posedge clk);
        #1;
        `CHK(power_save_active, 1'b0)
    endtask

    // main sequence
    initial
    begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        masked_attach();
        unmask_release();
        manual_swap();
        unmasked_hold();
        keys();
        power();
        results();
    end
endmodule // tb_ascl_top
